// file: rtl/cdb_pkg.sv
// Package: register map, field positions, reset values and states of the codec serial buffer
package cdb_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int ADDR_W      = 4;
    localparam int DATA_W      = 16;
    localparam int NUM_LOC     = 4;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] REG_CTRL1    = 4'h0;
    localparam logic [3:0] REG_CTRL2    = 4'h1;
    localparam logic [3:0] REG_FRAME    = 4'h2;
    localparam logic [3:0] REG_STATUS   = 4'h3;
    localparam logic [3:0] REG_TX_MASK  = 4'h4;
    localparam logic [3:0] REG_RX_MASK  = 4'h5;
    localparam logic [3:0] REG_IRQ_FLAG = 4'h6;
    localparam logic [3:0] REG_TXH_BASE = 4'h8;
    localparam logic [3:0] REG_RXH_BASE = 4'hC;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL1_LOOP_BIT   = 11;
    localparam int CTRL1_REPEAT_BIT = 7;
    localparam int CTRL1_IRQ_EN_BIT = 0;
    localparam int CTRL2_EARLY_BIT  = 5;
    localparam int CTRL2_WPI_LSB    = 10;
    localparam int FRAME_WS_LSB     = 0;
    localparam int FRAME_CNT_LSB    = 4;
    localparam int STAT_TX_EMPTY    = 0;
    localparam int STAT_TX_UNF      = 1;
    localparam int STAT_RX_FULL     = 2;
    localparam int STAT_RX_OVF      = 3;
    localparam int STAT_SLOT_LSB    = 7;
    localparam int IRQ_FLAG_BIT     = 9;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] CTRL1_RST = 16'h0000;
    localparam logic [15:0] CTRL2_RST = 16'h0000;
    localparam logic [15:0] FRAME_RST = 16'h000F;
    localparam logic [15:0] MASK_RST  = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } cdb_state_t;

    // Holding locations in use for a words_per_interrupt code
    function automatic logic [3:0] cdb_use_mask(input logic [1:0] wpi);
        logic [3:0] m;
        case (wpi)
            2'h0:    m = 4'h1;
            2'h1:    m = 4'h3;
            2'h2:    m = 4'h7;
            default: m = 4'hF;
        endcase
        return m;
    endfunction

endpackage

// file: rtl/cdb_link_if.sv
// Interface: synchronised link events from the pin front end to the serial engine
`timescale 1ns/100ps
interface cdb_link_if;
    logic sck_rise;
    logic sck_fall;
    logic fs_lvl;
    logic sdi_lvl;

    modport sync_mp (output sck_rise, output sck_fall, output fs_lvl, output sdi_lvl);
    modport eng_mp  (input sck_rise, input sck_fall, input fs_lvl, input sdi_lvl);
endinterface

// file: rtl/cdb_link_sync.sv
// Pin front end: two-stage synchronisers and serial clock edge detection
`timescale 1ns/100ps
module cdb_link_sync
    import cdb_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic serial_clk_in,
    input  wire logic frame_sync,
    input  wire logic serial_data_in,
    cdb_link_if.sync_mp lnk
);
    logic [2:0] raw;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic       sck_prev_q;

    assign raw = {serial_data_in, frame_sync, serial_clk_in};

    // ****************************************
    // Synchronisers
    // ****************************************
    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
            end else begin
                s1_q[g] <= raw[g];
                s2_q[g] <= s1_q[g];
            end
        end
    end

    // Data and frame sync delayed one more stage to line up with the edge pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_prev_q   <= 1'b0;
            lnk.sck_rise <= 1'b0;
            lnk.sck_fall <= 1'b0;
            lnk.fs_lvl   <= 1'b0;
            lnk.sdi_lvl  <= 1'b0;
        end else begin
            sck_prev_q   <= s2_q[0];
            lnk.sck_rise <= s2_q[0] & ~sck_prev_q;
            lnk.sck_fall <= ~s2_q[0] & sck_prev_q;
            lnk.fs_lvl   <= s2_q[1];
            lnk.sdi_lvl  <= s2_q[2];
        end
    end
endmodule // cdb_link_sync

// file: rtl/cdb_serial_buffer.sv
// Codec serial interface: holding registers, buffer transfers, status flags and serial engine
`timescale 1ns/100ps
// Contract
// - Receive flags use only in-use locations
// - Full flag set on transfer, cleared after reads
// - Overflow when unread location gets overwritten
// - Reading offending location clears overflow
// - Transmit flags use only in-use locations
// - Empty flag set when holdings move out
// - Writing any in-use holding clears empty
// - Underflow when in-use holding left unwritten
// - Writing offending location clears underflow
// - Status shows currently active slot index
// - Loopback feeds output back, ignores input
// - Underflow sends zeros or repeats last value
// - Justify bit chooses data start clock
// - Transfer at buffer length or frame end
// - Transfer swaps holdings with buffer memory
// - Two-bit code selects one to four words
// - Holdings double-buffered against engine memory
// - Interrupt flag set every transfer
// - Pointer returns to first at wrap, frame
// - Left-justified words, unused low bits zero
module cdb_serial_buffer
    import cdb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic              serial_clk_in,
    input  wire logic              frame_sync,
    input  wire logic              serial_data_in,
    output logic                   serial_data_out,
    output logic                   irq_req
);
    logic [15:0] ctrl1_q;
    logic [15:0] ctrl2_q;
    logic [15:0] frame_q;
    logic [15:0] tx_mask_q;
    logic [15:0] rx_mask_q;
    logic [15:0] txh_q     [NUM_LOC];
    logic [15:0] rxh_q     [NUM_LOC];
    logic [15:0] tx_mem_q  [NUM_LOC];
    logic [15:0] rx_mem_q  [NUM_LOC];
    logic [15:0] tx_new    [NUM_LOC];
    logic [3:0]  tx_written_q;
    logic [3:0]  rx_unread_q;
    logic [3:0]  rx_ovf_loc_q;
    logic [3:0]  tx_unf_loc_q;
    logic        tx_empty_q;
    logic        rx_full_q;
    logic        irq_flag_q;
    logic        irq_req_q;
    cdb_state_t  state_q;
    logic [3:0]  slot_q;
    logic [3:0]  bit_q;
    logic [1:0]  ptr_q;
    logic [15:0] tx_shift_q;
    logic [15:0] rx_shift_q;
    logic        sdo_q;
    logic [15:0] rd_data_q;

    logic        loop_en;
    logic        repeat_en;
    logic        early;
    logic        irq_en;
    logic [1:0]  wpi;
    logic [3:0]  use_mask;
    logic [3:0]  ws;
    logic [3:0]  frame_last;
    logic [1:0]  idx;
    logic        wr_txh;
    logic        rd_rxh;
    logic        start;
    logic        sample;
    logic        din;
    logic        word_done;
    logic        slot_act;
    logic        frame_end;
    logic        adv;
    logic        xfer;
    logic        restart;
    logic        store_rx;
    logic [15:0] rx_cat;
    logic [15:0] rx_word;
    logic [1:0]  ptr_next;
    logic [3:0]  slot_nx;
    logic [15:0] first_word;
    logic [15:0] next_load;
    logic        tx_any;
    logic        rx_any;

    cdb_link_if lnk ();

    cdb_link_sync u_sync (
        .clk            (clk),
        .rst            (rst),
        .serial_clk_in  (serial_clk_in),
        .frame_sync     (frame_sync),
        .serial_data_in (serial_data_in),
        .lnk            (lnk.sync_mp)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************
    // Decode
    // ****************************************
    assign loop_en    = ctrl1_q[CTRL1_LOOP_BIT];
    assign repeat_en  = ctrl1_q[CTRL1_REPEAT_BIT];
    assign irq_en     = ctrl1_q[CTRL1_IRQ_EN_BIT];
    assign early      = ctrl2_q[CTRL2_EARLY_BIT];
    assign wpi        = ctrl2_q[CTRL2_WPI_LSB +: 2];
    assign use_mask   = cdb_use_mask(wpi);
    assign ws         = frame_q[FRAME_WS_LSB +: 4];
    assign frame_last = frame_q[FRAME_CNT_LSB +: 4];
    assign idx        = addr[1:0];
    assign wr_txh     = wr_en && (addr[3:2] == REG_TXH_BASE[3:2]);
    assign rd_rxh     = rd_en && (addr[3:2] == REG_RXH_BASE[3:2]);
    assign tx_any     = |tx_mask_q;
    assign rx_any     = |rx_mask_q;

    // ****************************************
    // Serial timing and buffer pointer
    // ****************************************
    assign start     = lnk.sck_rise && (state_q == ST_IDLE) && lnk.fs_lvl;
    // Early mode samples the first bit on the same edge that sees frame sync
    assign sample    = lnk.sck_rise && ((state_q == ST_RUN) || (start && early));
    assign din       = loop_en ? sdo_q : lnk.sdi_lvl;
    assign word_done = sample && (bit_q == ws);
    assign slot_act  = tx_mask_q[slot_q] | rx_mask_q[slot_q];
    assign frame_end = word_done && (slot_q == frame_last);
    assign adv       = word_done && slot_act;
    assign xfer      = (adv && (ptr_q == wpi)) || frame_end;
    // In late mode the next frame sync can coincide with the last bit
    assign restart   = frame_end && lnk.fs_lvl && !early;
    assign store_rx  = adv && rx_mask_q[slot_q];
    assign rx_cat    = {rx_shift_q[14:0], din};
    assign rx_word   = rx_cat << (4'hF - ws);
    assign ptr_next  = xfer ? 2'h0 : (adv ? ptr_q + 2'h1 : ptr_q);
    assign slot_nx   = frame_end ? 4'h0 : slot_q + 4'h1;
    assign first_word = tx_mask_q[0] ? tx_mem_q[0] : 16'h0000;

    always_comb begin
        for (int i = 0; i < NUM_LOC; i++) begin
            tx_new[i] = (tx_written_q[i] || repeat_en) ? txh_q[i] : 16'h0000;
        end
    end

    // A word loaded on the transfer edge must see the freshly moved value
    always_comb begin
        next_load = xfer ? tx_new[ptr_next] : tx_mem_q[ptr_next];
        if (!tx_mask_q[slot_nx]) begin
            next_load = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            slot_q     <= 4'h0;
            bit_q      <= 4'h0;
            ptr_q      <= 2'h0;
            tx_shift_q <= 16'h0000;
            rx_shift_q <= 16'h0000;
        end else begin
            if (start) begin
                state_q    <= ST_RUN;
                slot_q     <= 4'h0;
                bit_q      <= 4'h0;
                ptr_q      <= 2'h0;
                rx_shift_q <= 16'h0000;
                tx_shift_q <= early ? (first_word << 1) : first_word;
            end
            if (sample) begin
                rx_shift_q <= word_done ? 16'h0000 : rx_cat;
                bit_q      <= word_done ? 4'h0 : bit_q + 4'h1;
                if (word_done) begin
                    slot_q     <= slot_nx;
                    ptr_q      <= ptr_next;
                    tx_shift_q <= next_load;
                    if (frame_end && !restart) begin
                        state_q <= ST_IDLE;
                    end
                end
            end else if (lnk.sck_fall && (state_q == ST_RUN)) begin
                tx_shift_q <= tx_shift_q << 1;
            end
        end
    end

    // Output changes on the falling edge so the codec samples it stable
    always_ff @(posedge clk) begin
        if (rst) begin
            sdo_q <= 1'b0;
        end else if (state_q != ST_RUN) begin
            // In early justify the idle line already shows the first bit, since it is sampled with sync; late holds it low
            sdo_q <= early ? first_word[15] : 1'b0;
        end else if (lnk.sck_fall) begin
            sdo_q <= tx_shift_q[15];
        end
    end

    sequence s_start_late;
        start && !early;
    endsequence
    sequence s_start_early;
        start && early && (ws != 4'h0);
    endsequence

    AST_LATE_START: assert property (s_start_late |=> (state_q == ST_RUN) && (bit_q == 4'h0))
        else $error("late justify sampled a bit on the frame sync edge");
    AST_EARLY_START: assert property (s_start_early |=> (bit_q == 4'h1))
        else $error("early justify did not sample on the frame sync edge");
    AST_PTR_WRAP: assert property (xfer |=> (ptr_q == 2'h0))
        else $error("buffer pointer not returned after transfer");
    AST_LOOP_IN: assert property (loop_en && sample |-> (rx_cat[0] == sdo_q))
        else $error("loopback did not take serial output");

    // ****************************************
    // Buffer memory and holding registers
    // ****************************************
    for (genvar g = 0; g < NUM_LOC; g++) begin : g_loc
        always_ff @(posedge clk) begin
            if (rst) begin
                tx_mem_q[g] <= 16'h0000;
                rx_mem_q[g] <= 16'h0000;
                rxh_q[g]    <= 16'h0000;
                txh_q[g]    <= 16'h0000;
            end else begin
                if (xfer) tx_mem_q[g] <= tx_new[g];
                if (store_rx && (ptr_q == 2'(g))) rx_mem_q[g] <= rx_word;
                if (xfer && use_mask[g]) begin
                    rxh_q[g] <= (store_rx && (ptr_q == 2'(g))) ? rx_word : rx_mem_q[g];
                end
                if (wr_txh && (idx == 2'(g))) txh_q[g] <= wr_data;
            end
        end

        // Clear first, then set, so an event in the clearing cycle wins
        always_ff @(posedge clk) begin
            if (rst) begin
                rx_unread_q[g]  <= 1'b0;
                rx_ovf_loc_q[g] <= 1'b0;
                tx_written_q[g] <= 1'b0;
                tx_unf_loc_q[g] <= 1'b0;
            end else begin
                if (rd_rxh && (idx == 2'(g))) begin
                    rx_unread_q[g]  <= 1'b0;
                    rx_ovf_loc_q[g] <= 1'b0;
                end
                if (xfer && use_mask[g] && rx_any) begin
                    rx_unread_q[g] <= 1'b1;
                    if (rx_unread_q[g]) rx_ovf_loc_q[g] <= 1'b1;
                end
                if (xfer) tx_written_q[g] <= 1'b0;
                if (wr_txh && (idx == 2'(g))) begin
                    tx_written_q[g] <= 1'b1;
                    tx_unf_loc_q[g] <= 1'b0;
                end
                if (xfer && use_mask[g] && tx_any && !tx_written_q[g]) begin
                    tx_unf_loc_q[g] <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_empty_q <= 1'b0;
            rx_full_q  <= 1'b0;
            irq_flag_q <= 1'b0;
            irq_req_q  <= 1'b0;
        end else begin
            if (wr_txh && use_mask[idx]) tx_empty_q <= 1'b0;
            if (xfer && tx_any) tx_empty_q <= 1'b1;
            if (rd_rxh && ((rx_unread_q & use_mask & ~(4'h1 << idx)) == 4'h0)) begin
                rx_full_q <= 1'b0;
            end
            if (xfer && rx_any) rx_full_q <= 1'b1;
            if (wr_en && (addr == REG_IRQ_FLAG) && !wr_data[IRQ_FLAG_BIT]) irq_flag_q <= 1'b0;
            if (xfer) irq_flag_q <= 1'b1;
            irq_req_q <= irq_flag_q && irq_en;
        end
    end

    AST_RXFULL_SET: assert property (xfer && rx_any |=> rx_full_q)
        else $error("receive full not set at transfer");
    AST_OVF_SET: assert property (xfer && rx_any && ((rx_unread_q & use_mask) != 4'h0)
                                  |=> ((rx_ovf_loc_q & use_mask) != 4'h0))
        else $error("receive overflow not raised");
    AST_OVF_CLR: assert property (rd_rxh && !xfer |=> !rx_ovf_loc_q[$past(idx)])
        else $error("reading the location did not clear overflow");
    AST_EMPTY_SET: assert property (xfer && tx_any
                                    |=> tx_empty_q ##1 (tx_empty_q || $past(wr_txh)))
        else $error("transmit empty not set at transfer");
    AST_EMPTY_CLR: assert property (wr_txh && use_mask[idx] && !xfer |=> !tx_empty_q)
        else $error("transmit empty not cleared by write");
    AST_UNF_SET: assert property (xfer && tx_any && ((~tx_written_q & use_mask) != 4'h0)
                                  |=> ((tx_unf_loc_q & use_mask) != 4'h0))
        else $error("transmit underflow not raised");
    AST_IRQ: assert property (xfer |=> irq_flag_q ##1 (irq_req_q == irq_en))
        else $error("interrupt flag or request missing after transfer");

    // ****************************************
    // Register port
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_q   <= CTRL1_RST;
            ctrl2_q   <= CTRL2_RST;
            frame_q   <= FRAME_RST;
            tx_mask_q <= MASK_RST;
            rx_mask_q <= MASK_RST;
        end else if (wr_en) begin
            case (addr)
                REG_CTRL1:   ctrl1_q   <= wr_data;
                REG_CTRL2:   ctrl2_q   <= wr_data;
                REG_FRAME:   frame_q   <= wr_data;
                REG_TX_MASK: tx_mask_q <= wr_data;
                REG_RX_MASK: rx_mask_q <= wr_data;
                default:     ;
            endcase
        end
    end

    // Unmapped offsets read as zero; data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst || !rd_en) begin
            rd_data_q <= 16'h0000;
        end else if (rd_rxh) begin
            rd_data_q <= rxh_q[idx];
        end else if (wr_txh || (addr[3:2] == REG_TXH_BASE[3:2])) begin
            rd_data_q <= txh_q[idx];
        end else begin
            case (addr)
                REG_CTRL1:    rd_data_q <= ctrl1_q;
                REG_CTRL2:    rd_data_q <= ctrl2_q;
                REG_FRAME:    rd_data_q <= frame_q;
                REG_TX_MASK:  rd_data_q <= tx_mask_q;
                REG_RX_MASK:  rd_data_q <= rx_mask_q;
                REG_IRQ_FLAG: rd_data_q <= 16'(irq_flag_q) << IRQ_FLAG_BIT;
                REG_STATUS:   rd_data_q <= {5'h00, slot_q, 3'h0,
                                            |(rx_ovf_loc_q & use_mask),
                                            rx_full_q,
                                            |(tx_unf_loc_q & use_mask),
                                            tx_empty_q};
                default:      rd_data_q <= 16'h0000;
            endcase
        end
    end

    assign rd_data         = rd_data_q;
    assign serial_data_out = sdo_q;
    assign irq_req         = irq_req_q;

endmodule // cdb_serial_buffer

// file: verification/cdb_codec_model.sv
// Codec model: frame source and sink on the far side of the serial link
`timescale 1ns/100ps
module cdb_codec_model (
    output logic      sclk,
    output logic      fs,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic early
);
    initial begin
        sclk = 1'b0;
        fs   = 1'b0;
        sdi  = 1'b0;
    end

    // ****************************************
    // One 8-bit slot, late or early justified
    // ****************************************
    // Serial clock stands still low between frames; edges sit off the system clock edges
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        int k;
        k = 7;
        #20 fs = 1'b1;
        if (early) begin
            sdi = tx[7];
        end
        #400 sclk = 1'b1;
        if (early) begin
            rx[7] = sdo;
            k = 6;
        end
        while (k >= 0) begin
            #400 sclk = 1'b0;
            fs  = 1'b0;
            sdi = tx[k];
            #400 sclk = 1'b1;
            rx[k] = sdo;
            k--;
        end
        #400 sclk = 1'b0;
        // Released line must not keep its last level
        sdi = ~tx[0];
    endtask
endmodule // cdb_codec_model

// file: verification/cdb_serial_buffer_tb_top.sv
// Testbench: register bus, buffer transfers and status flags of the codec serial buffer
`timescale 1ns/100ps
module cdb_serial_buffer_tb_top
    import cdb_pkg::*;
;
    logic              clk;
    logic              rst;
    logic              wr_en;
    logic              rd_en;
    logic              sclk;
    logic              fs;
    logic              sdi;
    logic              sdo;
    logic              early_m;
    logic              irq_req;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] d;
    logic [7:0]        got;
    int                n_fail;
    int                checks_done;

    cdb_serial_buffer dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .serial_clk_in(sclk),
        .frame_sync(fs), .serial_data_in(sdi), .serial_data_out(sdo), .irq_req(irq_req));
    cdb_codec_model codec (.sclk(sclk), .fs(fs), .sdi(sdi), .sdo(sdo), .early(early_m));

    always #50 clk = ~clk;

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask

    // Flags land a few clocks after the synchronised last bit
    task automatic xfr(input logic [7:0] tx);
        codec.frame(tx, got);
        repeat (12) @(posedge clk);
    endtask

    task automatic stat(input logic [3:0] e, input string m);
        rd(REG_STATUS, d);
        chk(d & 16'h000F, {12'h000, e}, m);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd(REG_FRAME, d);
        chk(d, FRAME_RST, "frame cfg reset");
        wr(REG_STATUS, 16'hFFFF);
        stat(4'h0, "status read-only");
        rd(4'h7, d);
        chk(d, 16'h0000, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_flags();
        wr(REG_FRAME, 16'h0007);
        wr(REG_TX_MASK, 16'h0001);
        wr(REG_RX_MASK, 16'h0001);
        wr(REG_CTRL1, 16'h0001);
        wr(REG_TXH_BASE, 16'h3CFF);
        xfr(8'hA5);
        stat(4'h5, "empty and full set");
        chk({15'h0000, irq_req}, 16'h0001, "irq request");
        rd(REG_IRQ_FLAG, d);
        chk(d & 16'h0200, 16'h0200, "irq flag");
        rd(REG_RXH_BASE, d);
        chk(d, 16'hA500, "rx word left justified");
        stat(4'h1, "full clears on read");
        wr(REG_TXH_BASE, 16'h5AFF);
        stat(4'h0, "empty clears on write");
        wr(REG_IRQ_FLAG, 16'h0000);
        repeat (2) @(posedge clk);
        chk({15'h0000, irq_req}, 16'h0000, "irq cleared");
        $display("test flags done");
    endtask

    task automatic t_ovf_unf();
        xfr(8'h81);
        chk({8'h00, got}, 16'h003C, "tx low bits ignored");
        xfr(8'h42);
        chk({8'h00, got}, 16'h005A, "second tx word");
        stat(4'hF, "overflow and underflow");
        rd(REG_RXH_BASE, d);
        chk(d, 16'h4200, "overwritten rx word");
        stat(4'h3, "overflow clears on read");
        xfr(8'h00);
        chk({8'h00, got}, 16'h0000, "underflow sends zeros");
        wr(REG_CTRL1, 16'h0081);
        xfr(8'h00);
        xfr(8'h00);
        chk({8'h00, got}, 16'h005A, "underflow repeats");
        wr(REG_TXH_BASE, 16'h99FF);
        stat(4'hC, "underflow clears on write");
        $display("test overflow underflow done");
    endtask

    task automatic t_loop();
        wr(REG_CTRL1, 16'h0881);
        xfr(8'h66);
        rd(REG_RXH_BASE, d);
        chk(d, 16'h5A00, "loopback ignores input");
        xfr(8'h66);
        chk({8'h00, got}, 16'h0099, "loopback word on pin");
        $display("test loopback done");
    endtask

    // Two words per interrupt, first bit out together with frame sync
    task automatic t_early();
        wr(REG_CTRL1, 16'h0001);
        wr(REG_CTRL2, 16'h0420);
        early_m <= 1'b1;
        xfr(8'hC3);
        chk({8'h00, got}, 16'h0099, "early tx word");
        rd(REG_RXH_BASE, d);
        chk(d, 16'hC300, "early rx word");
        stat(4'h7, "full waits for both words");
        rd(4'hD, d);
        chk(d, 16'h0000, "unfilled second word");
        stat(4'h3, "full clears after both reads");
        wr(REG_TXH_BASE, 16'h1200);
        stat(4'h2, "underflow kept by unwritten word");
        wr(REG_RX_MASK, 16'h0000);
        xfr(8'h00);
        stat(4'h3, "transmit only transfer seen by empty");
        $display("test early justify done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clk         = 1'b0;
        rst         = 1'b1;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        early_m     = 1'b0;
        addr        = '0;
        wr_data     = '0;
        n_fail      = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_flags();
        t_ovf_unf();
        t_loop();
        t_early();
        tally_and_finish();
    end

    // Ten frames of about 8 us each fit well inside this span
    initial begin
        #2000000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule // cdb_serial_buffer_tb_top
